// ==== rtl/rrmux_pkg.sv ====
// Package of constants and types for the readback register multiplexer.
package rrmux_pkg;

  // ----------------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------------
  localparam logic [4:0] READBACK_VALUE_ADDR = 5'h1f;
  localparam logic [4:0] READBACK_SELECT_ADDR = 5'h1d;
  localparam logic [4:0] DEMAND_ADDR = 5'h1e;

  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  localparam int FAULT_FLAG_POS = 15;
  localparam int POR_FLAG_POS = 14;
  localparam int SERIAL_ERR_POS = 13;
  localparam int SEL_LSB = 1;
  localparam int SEL_MSB = 3;
  localparam int DEMAND_LSB = 1;
  localparam int DEMAND_MSB = 10;

  // ----------------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------------
  localparam logic [2:0] SEL_RESET = 3'h0;
  localparam logic [9:0] DEMAND_RESET = 10'h000;
  localparam logic [15:0] WORD_RESET = 16'h0000;

  // Readback sources, one per code of the select field.
  typedef enum logic [2:0] {
    RRMUX_SRC_DIAG = 3'h0,
    RRMUX_SRC_SPEED = 3'h1,
    RRMUX_SRC_CURRENT = 3'h2,
    RRMUX_SRC_SUPPLY = 3'h3,
    RRMUX_SRC_TEMP = 3'h4,
    RRMUX_SRC_DEMAND = 3'h5,
    RRMUX_SRC_DUTY = 3'h6,
    RRMUX_SRC_ADVANCE = 3'h7
  } rrmux_src_t;

  // Advance count that stands for the clamped 60 degree value in manual mode.
  localparam logic [9:0] ADV_MANUAL_MAX = 10'h03f;

endpackage

// ==== rtl/rrmux_top.sv ====
// Readback register multiplexer of the motor controller serial register bank.
//
// Contract
// R1 - Top three bits carry fault, reset, serial-error flags.
// R2 - Select field picks one of eight sources.
// R3 - Code 0: bits 8..6 are bootstrap faults.
// R4 - Code 0: bits 5..0 VDS faults, bit 9 overspeed.
// R5 - Code 1 returns electrical speed count.
// R6 - Overflow bit is the eleventh speed bit; the code puts it at code 0 bit 9 and code 1 bit 10 reads 0.
// R7 - Speed stays valid during forward windmill detection.
// R8 - Code 2 returns average supply current count.
// R9 - Code 3 returns supply voltage count.
// R10 - Code 4 returns chip temperature count.
// R11 - Code 5 echoes last written demand value.
// R12 - Code 6 returns applied peak duty cycle.
// R13 - Code 7 manual: advance count, 63 means 60.
// R14 - Code 7 automatic: advance count linear, unchanged.
// R15 - Writes to address 31 change nothing.
// R16 - Select field lives in select register, resets 0.
// R17 - Value captured once at read frame start.
`timescale 1ns/1ns
module rrmux_top (
  input wire logic CLK_SYS_I,
  input wire logic RST_I,
  input wire logic FRAME_START_I,
  input wire logic [4:0] ADDR_I,
  input wire logic WRITE_I,
  input wire logic [15:0] WDATA_I,
  input wire logic SUMMARY_FAULT_FLAG_I,
  input wire logic POR_FLAG_I,
  input wire logic SERIAL_ERROR_FLAG_I,
  input wire logic SPEED_OVERFLOW_BIT_I,
  input wire logic [2:0] BOOT_FAULT_I,
  input wire logic [5:0] VDS_FAULT_I,
  input wire logic [9:0] SPEED_COUNT_I,
  input wire logic SPEED_VALID_I,
  input wire logic WINDMILL_FWD_I,
  input wire logic [9:0] CURRENT_COUNT_I,
  input wire logic [9:0] SUPPLY_COUNT_I,
  input wire logic [9:0] TEMP_COUNT_I,
  input wire logic [9:0] DUTY_COUNT_I,
  input wire logic [9:0] ADVANCE_COUNT_I,
  input wire logic ADVANCE_MODE_SELECT_I,
  output logic [15:0] READBACK_VALUE_O,
  output logic [2:0] READBACK_SOURCE_SELECT_O,
  output logic [9:0] DEMAND_VALUE_O
);

  // ----------------------------------------------------------------------
  // Writable registers
  // ----------------------------------------------------------------------
  logic [2:0] sel;
  logic [9:0] demand;
  logic [9:0] speed_hold;
  wire sel_wr = WRITE_I && (ADDR_I == rrmux_pkg::READBACK_SELECT_ADDR);
  wire dem_wr = WRITE_I && (ADDR_I == rrmux_pkg::DEMAND_ADDR);
  wire [2:0] next_sel = sel_wr ? WDATA_I[rrmux_pkg::SEL_MSB:rrmux_pkg::SEL_LSB] : sel;
  wire [9:0] next_demand = dem_wr ?
    WDATA_I[rrmux_pkg::DEMAND_MSB:rrmux_pkg::DEMAND_LSB] : demand;

  always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
    if (RST_I) begin
      sel <= rrmux_pkg::SEL_RESET; // [R16]
      demand <= rrmux_pkg::DEMAND_RESET;
    end else begin
      sel <= next_sel; // [R15]
      demand <= next_demand;
    end
  end

  // ----------------------------------------------------------------------
  // Source selection
  // ----------------------------------------------------------------------
  // The speed count is followed while driving or windmilling forward, and
  // held otherwise so a stale transient never reaches the host.
  wire speed_live = SPEED_VALID_I || WINDMILL_FWD_I; // [R7]
  wire [9:0] next_speed_hold = speed_live ? SPEED_COUNT_I : speed_hold;
  always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
    if (RST_I) begin
      speed_hold <= rrmux_pkg::DEMAND_RESET;
    end else begin
      speed_hold <= next_speed_hold;
    end
  end

  wire [9:0] diag_word = {SPEED_OVERFLOW_BIT_I, BOOT_FAULT_I, VDS_FAULT_I}; // [R3] [R4]
  wire [9:0] speed_word = speed_live ? SPEED_COUNT_I : speed_hold; // [R5]
  // Manual mode tops out at the clamp code; automatic is passed linearly.
  wire adv_over = !ADVANCE_MODE_SELECT_I && (ADVANCE_COUNT_I > rrmux_pkg::ADV_MANUAL_MAX);
  wire [9:0] adv_word = adv_over ? rrmux_pkg::ADV_MANUAL_MAX : ADVANCE_COUNT_I; // [R13] [R14]

  logic [9:0] sel_word;
  always_comb begin
    unique case (rrmux_pkg::rrmux_src_t'(sel)) // [R2]
      rrmux_pkg::RRMUX_SRC_DIAG: sel_word = diag_word;
      rrmux_pkg::RRMUX_SRC_SPEED: sel_word = speed_word;
      rrmux_pkg::RRMUX_SRC_CURRENT: sel_word = CURRENT_COUNT_I; // [R8]
      rrmux_pkg::RRMUX_SRC_SUPPLY: sel_word = SUPPLY_COUNT_I; // [R9]
      rrmux_pkg::RRMUX_SRC_TEMP: sel_word = TEMP_COUNT_I; // [R10]
      rrmux_pkg::RRMUX_SRC_DEMAND: sel_word = demand; // [R11]
      rrmux_pkg::RRMUX_SRC_DUTY: sel_word = DUTY_COUNT_I; // [R12]
      rrmux_pkg::RRMUX_SRC_ADVANCE: sel_word = adv_word;
    endcase
  end

  wire [15:0] live_word = {SUMMARY_FAULT_FLAG_I, POR_FLAG_I, SERIAL_ERROR_FLAG_I,
                           3'h0, sel_word}; // [R1]

  // ----------------------------------------------------------------------
  // Frame capture
  // ----------------------------------------------------------------------
  // Capturing once per frame keeps all sixteen shifted bits from one instant.
  wire [15:0] next_word = FRAME_START_I ? live_word : READBACK_VALUE_O; // [R17]
  always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
    if (RST_I) begin
      READBACK_VALUE_O <= rrmux_pkg::WORD_RESET;
      READBACK_SOURCE_SELECT_O <= rrmux_pkg::SEL_RESET;
      DEMAND_VALUE_O <= rrmux_pkg::DEMAND_RESET;
    end else begin
      READBACK_VALUE_O <= next_word;
      READBACK_SOURCE_SELECT_O <= next_sel;
      DEMAND_VALUE_O <= next_demand;
    end
  end

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge CLK_SYS_I); endclocking
  default disable iff (RST_I);

  a_capture_flags: assert property (FRAME_START_I |=> // [R1]
    READBACK_VALUE_O[15:13] == $past({SUMMARY_FAULT_FLAG_I, POR_FLAG_I, SERIAL_ERROR_FLAG_I}))
    else $error("status flags not captured");
  a_reserved_zero: assert property (READBACK_VALUE_O[12:10] == 3'h0) // [R1]
    else $error("reserved bits not zero");
  a_diag_layout: assert property (FRAME_START_I && sel == 3'h0 |=> // [R3] [R4]
    READBACK_VALUE_O[9:0] == $past({SPEED_OVERFLOW_BIT_I, BOOT_FAULT_I, VDS_FAULT_I}))
    else $error("diagnostic layout wrong");
  a_demand_echo: assert property (dem_wr ##1 (sel == 3'h5 && FRAME_START_I && !dem_wr) |=> // [R11]
    READBACK_VALUE_O[9:0] == $past(WDATA_I[10:1], 2))
    else $error("demand echo wrong");
  a_ro_write: assert property (WRITE_I && ADDR_I == 5'h1f |=> $stable(sel) && $stable(demand)) // [R15]
    else $error("write to readback changed state");
  a_hold_word: assert property (!FRAME_START_I |=> $stable(READBACK_VALUE_O)) // [R17]
    else $error("word changed mid frame");
  a_adv_clamp: assert property (FRAME_START_I && sel == 3'h7 && !ADVANCE_MODE_SELECT_I |=> // [R13]
    READBACK_VALUE_O[9:0] <= 10'h03f)
    else $error("manual advance not clamped");
  a_adv_auto: assert property (FRAME_START_I && sel == 3'h7 && ADVANCE_MODE_SELECT_I |=> // [R14]
    READBACK_VALUE_O[9:0] == $past(ADVANCE_COUNT_I))
    else $error("automatic advance altered");
  a_speed_windmill: assert property (FRAME_START_I && sel == 3'h1 && WINDMILL_FWD_I |=> // [R7]
    READBACK_VALUE_O[9:0] == $past(SPEED_COUNT_I))
    else $error("speed lost in windmill");
  a_sel_source: assert property (FRAME_START_I && sel == 3'h3 |=> // [R2] [R9]
    READBACK_VALUE_O[9:0] == $past(SUPPLY_COUNT_I))
    else $error("supply source wrong");

  // ----------------------------------------------------------------------
  // Source assertions
  // ----------------------------------------------------------------------
  // Every source check but a_speed_track is made on the captured word one cycle after the strobe,
  // so these also cover the capture path and not just the selector.
  a_speed_drive: assert property (FRAME_START_I && SPEED_VALID_I && // [R5]
    sel == rrmux_pkg::RRMUX_SRC_SPEED |=>
    READBACK_VALUE_O[9:0] == $past(SPEED_COUNT_I))
    else $error("speed not returned while driving");
  // With the motor neither driven nor windmilling the count is meaningless,
  // so the host sees the last trusted value instead.
  a_speed_stale: assert property (FRAME_START_I && !SPEED_VALID_I && !WINDMILL_FWD_I && // [R7]
    sel == rrmux_pkg::RRMUX_SRC_SPEED |=>
    READBACK_VALUE_O[9:0] == $past(speed_hold))
    else $error("stale speed not held");
  a_speed_track: assert property (SPEED_VALID_I || WINDMILL_FWD_I |=> // [R7]
    speed_hold == $past(SPEED_COUNT_I))
    else $error("speed hold not following count");
  a_current_src: assert property (FRAME_START_I && // [R8]
    sel == rrmux_pkg::RRMUX_SRC_CURRENT |=> READBACK_VALUE_O[9:0] == $past(CURRENT_COUNT_I))
    else $error("current source wrong");
  a_temp_src: assert property (FRAME_START_I && // [R10]
    sel == rrmux_pkg::RRMUX_SRC_TEMP |=> READBACK_VALUE_O[9:0] == $past(TEMP_COUNT_I))
    else $error("temperature source wrong");
  a_demand_src: assert property (FRAME_START_I && // [R11]
    sel == rrmux_pkg::RRMUX_SRC_DEMAND |=> READBACK_VALUE_O[9:0] == $past(demand))
    else $error("demand source wrong");
  a_duty_src: assert property (FRAME_START_I && // [R12]
    sel == rrmux_pkg::RRMUX_SRC_DUTY |=> READBACK_VALUE_O[9:0] == $past(DUTY_COUNT_I))
    else $error("duty source wrong");
  a_adv_manual: assert property (FRAME_START_I && !ADVANCE_MODE_SELECT_I && // [R13]
    sel == rrmux_pkg::RRMUX_SRC_ADVANCE && ADVANCE_COUNT_I <= rrmux_pkg::ADV_MANUAL_MAX |=>
    READBACK_VALUE_O[9:0] == $past(ADVANCE_COUNT_I))
    else $error("manual advance altered");
  a_adv_top: assert property (FRAME_START_I && !ADVANCE_MODE_SELECT_I && // [R13]
    sel == rrmux_pkg::RRMUX_SRC_ADVANCE && ADVANCE_COUNT_I > rrmux_pkg::ADV_MANUAL_MAX |=>
    READBACK_VALUE_O[9:0] == rrmux_pkg::ADV_MANUAL_MAX)
    else $error("manual advance above top code");

  // ----------------------------------------------------------------------
  // Register assertions
  // ----------------------------------------------------------------------
  // The select and demand outputs are separate flops from the internal copies,
  // so they are checked against the bus word and not against each other.
  a_sel_write: assert property (sel_wr |=> // [R16]
    READBACK_SOURCE_SELECT_O == $past(WDATA_I[rrmux_pkg::SEL_MSB:rrmux_pkg::SEL_LSB]))
    else $error("select write not taken");
  a_demand_write: assert property (dem_wr |=> // [R11]
    DEMAND_VALUE_O == $past(WDATA_I[rrmux_pkg::DEMAND_MSB:rrmux_pkg::DEMAND_LSB]))
    else $error("demand write not taken");
  a_ro_outputs: assert property (WRITE_I && // [R15]
    ADDR_I == rrmux_pkg::READBACK_VALUE_ADDR |=>
    $stable(READBACK_SOURCE_SELECT_O) && $stable(DEMAND_VALUE_O))
    else $error("write to readback changed outputs");

  // ----------------------------------------------------------------------
  // Cover points
  // ----------------------------------------------------------------------
  c_diag_read: cover property (FRAME_START_I && sel == 3'h0 && |VDS_FAULT_I);
  c_speed_read: cover property (FRAME_START_I && sel == 3'h1 && SPEED_OVERFLOW_BIT_I);
  c_demand_echo: cover property (dem_wr ##1 sel == 3'h5 && FRAME_START_I);
  c_adv_clamp: cover property (FRAME_START_I && sel == 3'h7 && adv_over);
  c_windmill_read: cover property (FRAME_START_I && sel == 3'h1 &&
    WINDMILL_FWD_I && !SPEED_VALID_I);

endmodule

// ==== testbench/rrmux_host_model.sv ====
// Host model that issues register writes and read frames to the readback block.
`timescale 1ns/1ns
module rrmux_host_model (
  input wire logic clk_i,
  input wire logic [15:0] rdata_i,
  output logic frame_start_o,
  output logic [4:0] addr_o,
  output logic write_o,
  output logic [15:0] wdata_o
);
  initial begin
    frame_start_o = 1'b0;
    addr_o = 5'h00;
    write_o = 1'b0;
    wdata_o = 16'h0000;
  end
  // After the strobe the data is inverted, so a design that samples late sees junk.
  task automatic write_reg(input logic [4:0] a, input logic [15:0] d);
    @(posedge clk_i);
    addr_o <= a;
    wdata_o <= d;
    write_o <= 1'b1;
    @(posedge clk_i);
    write_o <= 1'b0;
    wdata_o <= ~d;
  endtask
  task automatic read_frame(output logic [15:0] q);
    @(posedge clk_i);
    frame_start_o <= 1'b1;
    @(posedge clk_i);
    frame_start_o <= 1'b0;
    #1;
    q = rdata_i;
  endtask
  // Write immediately followed by a frame, so the frame must see the new value.
  task automatic write_read(input logic [4:0] a, input logic [15:0] d, output logic [15:0] q);
    @(posedge clk_i);
    addr_o <= a;
    wdata_o <= d;
    write_o <= 1'b1;
    @(posedge clk_i);
    write_o <= 1'b0;
    wdata_o <= ~d;
    frame_start_o <= 1'b1;
    @(posedge clk_i);
    frame_start_o <= 1'b0;
    #1;
    q = rdata_i;
  endtask
endmodule

// ==== testbench/tb.sv ====
// Self-checking bench for the readback register multiplexer.
`timescale 1ns/1ns
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin n_fail++; \
  $display("MISMATCH %s expected %h seen %h", nm, e, g); end end
module tb;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic spd_ok = 1'b1, wind = 1'b0, advance_mode_select = 1'b1;
  logic [12:0] flg = 13'h0000;
  logic [9:0] src [8] = '{10'h000, 10'h3a5, 10'h1c3, 10'h2e7, 10'h0f1, 10'h15a, 10'h3ff, 10'h2c5};
  logic [15:0] rb, wdata, q;
  logic [4:0] addr;
  logic frame, wr;
  logic [2:0] sel;
  logic [9:0] dem;
  int n_fail = 0;
  int samples_checked = 0;
  always #5 clk = ~clk;
  rrmux_host_model rrmux_host_model_i (.clk_i(clk), .rdata_i(rb), .frame_start_o(frame),
    .addr_o(addr), .write_o(wr), .wdata_o(wdata));
  rrmux_top rrmux_top_i (.CLK_SYS_I(clk), .RST_I(rst), .FRAME_START_I(frame), .ADDR_I(addr),
    .WRITE_I(wr), .WDATA_I(wdata), .SUMMARY_FAULT_FLAG_I(flg[12]), .POR_FLAG_I(flg[11]),
    .SERIAL_ERROR_FLAG_I(flg[10]), .SPEED_OVERFLOW_BIT_I(flg[9]), .BOOT_FAULT_I(flg[8:6]),
    .VDS_FAULT_I(flg[5:0]), .SPEED_COUNT_I(src[1]), .SPEED_VALID_I(spd_ok),
    .WINDMILL_FWD_I(wind), .CURRENT_COUNT_I(src[2]), .SUPPLY_COUNT_I(src[3]),
    .TEMP_COUNT_I(src[4]), .DUTY_COUNT_I(src[6]), .ADVANCE_COUNT_I(src[7]),
    .ADVANCE_MODE_SELECT_I(advance_mode_select), .READBACK_VALUE_O(rb), .READBACK_SOURCE_SELECT_O(sel),
    .DEMAND_VALUE_O(dem));
  task automatic rd_check(input string nm, input logic [9:0] e);
    rrmux_host_model_i.read_frame(q);
    `CHK(nm, {flg[12:10], 3'h0, e}, q)
  endtask
  task automatic close_out();
    $display("Checks made %0d, mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // ------------------------------------------------------------------
  // Test sequence
  // ------------------------------------------------------------------
  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1;
    `CHK("select", rrmux_pkg::SEL_RESET, sel)
    flg <= 13'h1766;
    rd_check("diag", 10'h366);
    $display("reset and diag test done");
    rrmux_host_model_i.write_reg(rrmux_pkg::DEMAND_ADDR, {5'h00, src[5], 1'b0});
    for (int c = 1; c < 8; c++) begin
      rrmux_host_model_i.write_reg(rrmux_pkg::READBACK_SELECT_ADDR, {12'h000, c[2:0], 1'b0});
      rd_check("source", src[c]);
    end
    `CHK("demand", src[5], dem)
    advance_mode_select <= 1'b0;
    src[7] <= 10'h050;
    rd_check("clamped advance", 10'h03f);
    src[7] <= 10'h03e;
    rd_check("manual advance", 10'h03e);
    rrmux_host_model_i.write_reg(rrmux_pkg::READBACK_SELECT_ADDR, 16'h000a);
    rrmux_host_model_i.write_read(rrmux_pkg::DEMAND_ADDR, 16'h0532, q);
    `CHK("demand echo", {flg[12:10], 3'h0, 10'h299}, q)
    `CHK("demand output", 10'h299, dem)
    $display("source sweep test done");
    rrmux_host_model_i.write_reg(rrmux_pkg::READBACK_SELECT_ADDR, 16'h0002);
    spd_ok <= 1'b0;
    wind <= 1'b1;
    src[1] <= 10'h123;
    rd_check("windmill speed", 10'h123);
    src[1] <= 10'h2f0;
    repeat (3) @(posedge clk);
    #1;
    `CHK("held word", {flg[12:10], 3'h0, 10'h123}, rb)
    flg <= 13'h0800;
    rrmux_host_model_i.write_reg(rrmux_pkg::READBACK_VALUE_ADDR, 16'hffff);
    #1;
    `CHK("select kept", 3'h1, sel)
    `CHK("demand kept", 10'h299, dem)
    rd_check("after ignored write", 10'h2f0);
    wind <= 1'b0;
    src[1] <= 10'h111;
    rd_check("stale speed held", 10'h2f0);
    $display("windmill and read-only test done");
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1;
    `CHK("select after reset", rrmux_pkg::SEL_RESET, sel)
    `CHK("demand after reset", rrmux_pkg::DEMAND_RESET, dem)
    `CHK("word after reset", rrmux_pkg::WORD_RESET, rb)
    flg <= 13'h02a5;
    rd_check("diag after reset", 10'h2a5);
    $display("mid-run reset test done");
    close_out();
  end
  // The whole sequence needs about 65 cycles, so 2000 is a generous limit.
  initial begin
    #20000;
    n_fail++;
    close_out();
  end
endmodule
